// [core/rhsfp_pkg.sv]
// shared constants and types for the reader host serial fifo port
package rhsfp_pkg;

    // register addresses on the serial link
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h0d;
    localparam logic [4:0] ADDR_FIFO_STATUS = 5'h1c;
    localparam logic [4:0] ADDR_TX_LEN_HI = 5'h1d;
    localparam logic [4:0] ADDR_TX_LEN_LO = 5'h1e;
    localparam logic [4:0] ADDR_FIFO_DATA = 5'h1f;

    // command code that empties the fifo
    localparam logic [4:0] CMD_FIFO_RESET = 5'h0f;

    // first-word field positions
    localparam int WORD_CMD_BIT = 7;
    localparam int WORD_READ_BIT = 6;
    localparam int WORD_CONT_BIT = 5;
    localparam int BYTE_BITS = 8;

    // status bit positions
    localparam int IRQ_TX_BIT = 7;
    localparam int FIFO_OVF_BIT = 4;
    localparam int FIFO_LO_BIT = 5;
    localparam int FIFO_HI_BIT = 6;

    // reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // strap codes, ordered {io2, io1, io0}
    localparam logic [2:0] STRAP_SPI_SS = 3'h6;
    localparam logic [2:0] STRAP_SPI_NOSS = 3'h4;

    // fifo geometry and thresholds
    localparam int FIFO_DEPTH = 12;
    localparam logic [3:0] FIFO_LO_LEVEL = 4'h3;
    localparam logic [3:0] FIFO_HI_LEVEL = 4'h9;
    localparam logic [12:0] SHORT_FRAME_MAX = 13'h0004;

    // pins from outside the clock domain
    typedef struct packed {
        logic [2:0] strap;
        logic sclk;
        logic mosi;
        logic ssn;
    } rhsfp_pins_t;

    typedef enum logic [2:0] {
        MODE_PAR = 3'h1,
        MODE_SPI_SS = 3'h2,
        MODE_SPI_NOSS = 3'h4
    } rhsfp_mode_t;

    typedef enum logic [3:0] {
        ST_WORD = 4'h1,
        ST_WDATA = 4'h2,
        ST_RDATA = 4'h4,
        ST_CMD = 4'h8
    } rhsfp_state_t;

endpackage

// [core/rhsfp_sync.sv]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module rhsfp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // the first stage feeds only the second
    always_comb begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk) begin
        meta_q <= meta_d;
        o_q <= sync_d;
    end
endmodule // rhsfp_sync

// [core/rhsfp_top.sv]
// reader host serial port: spi front end, registers and transmit fifo
`timescale 1ns/100ps
module rhsfp_top #(
    parameter int FIFO_DEPTH = rhsfp_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_strap,
    input wire logic i_sclk,
    input wire logic i_mosi,
    input wire logic i_ssn,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_irq,
    input wire logic i_tx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    output rhsfp_pkg::rhsfp_mode_t o_mode
);
    localparam logic [3:0] DEPTH4 = 4'(FIFO_DEPTH);

    // the counter field and the high level need 10..15 entries
    if (FIFO_DEPTH < 10 || FIFO_DEPTH > 15) begin : g_bad_depth
        $error("fifo depth must lie between 10 and 15");
    end

    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    rhsfp_pkg::rhsfp_pins_t pins_raw;
    rhsfp_pkg::rhsfp_pins_t pins_s;
    assign pins_raw = '{strap: i_strap, sclk: i_sclk, mosi: i_mosi,
                        ssn: i_ssn};

    rhsfp_sync #(
        .WIDTH($bits(rhsfp_pkg::rhsfp_pins_t))
    ) u_sync (
        .i_clk(i_clk),
        .i_d(pins_raw),
        .o_q(pins_s)
    );

    // serial front end state
    rhsfp_pkg::rhsfp_mode_t mode_q, mode_d;
    rhsfp_pkg::rhsfp_state_t state_q, state_d;
    logic strap_done_q, strap_done_d;
    logic sclk_prev_q, sclk_prev_d, mosi_prev_q, mosi_prev_d;
    logic active_q, active_d, cont_q, cont_d;
    logic [2:0] bitcnt_q, bitcnt_d;
    logic [7:0] shin_q, shin_d, shout_q, shout_d;
    logic [4:0] addr_q, addr_d, rd_addr;
    logic [7:0] byte_in, rd_data;
    logic sclk_rise, start_cond, stop_cond, link_on, link_reset;
    logic ss_mode, noss_mode;
    logic byte_done, wr_stb, rd_stb, cmd_stb;

    assign ss_mode = (mode_q == rhsfp_pkg::MODE_SPI_SS);
    assign noss_mode = (mode_q == rhsfp_pkg::MODE_SPI_NOSS);
    assign sclk_rise = pins_s.sclk & ~sclk_prev_q;
    // data edges while clock stays high delimit frames
    assign start_cond = pins_s.sclk & sclk_prev_q & pins_s.mosi & ~mosi_prev_q;
    assign stop_cond = pins_s.sclk & sclk_prev_q & ~pins_s.mosi & mosi_prev_q;
    assign link_on = ss_mode ? ~pins_s.ssn : active_q;
    assign link_reset = (mode_q == rhsfp_pkg::MODE_PAR)
        | (ss_mode & pins_s.ssn)
        | (noss_mode & (start_cond | stop_cond));
    assign byte_in = {shin_q[6:0], pins_s.mosi};
    assign rd_addr = (state_q == rhsfp_pkg::ST_WORD) ? byte_in[4:0]
                                                     : addr_q + 5'h01;

    // strap capture, bit shifting and word decoding
    always_comb begin
        mode_d = mode_q;
        strap_done_d = 1'b1;
        sclk_prev_d = pins_s.sclk;
        mosi_prev_d = pins_s.mosi;
        state_d = state_q;
        active_d = active_q;
        cont_d = cont_q;
        bitcnt_d = bitcnt_q;
        shin_d = shin_q;
        shout_d = shout_q;
        addr_d = addr_q;
        byte_done = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cmd_stb = 1'b0;
        if (!strap_done_q) begin
            case (pins_s.strap)
                rhsfp_pkg::STRAP_SPI_SS: mode_d = rhsfp_pkg::MODE_SPI_SS;
                rhsfp_pkg::STRAP_SPI_NOSS: mode_d = rhsfp_pkg::MODE_SPI_NOSS;
                // other unequal codes still pick a serial variant
                default: mode_d = (&pins_s.strap || ~|pins_s.strap)
                    ? rhsfp_pkg::MODE_PAR : pins_s.strap[1]
                    ? rhsfp_pkg::MODE_SPI_SS : rhsfp_pkg::MODE_SPI_NOSS;
            endcase
        end
        if (link_reset) begin
            active_d = noss_mode & start_cond;
            bitcnt_d = 3'h0;
            state_d = rhsfp_pkg::ST_WORD;
            shout_d = 8'h00;
        end else if (link_on && sclk_rise) begin
            shin_d = byte_in;
            bitcnt_d = bitcnt_q + 3'h1;
            shout_d = {shout_q[6:0], 1'b0};
            if (bitcnt_q == 3'h7) begin
                byte_done = 1'b1;
                case (state_q)
                    rhsfp_pkg::ST_WORD: begin
                        if (byte_in[rhsfp_pkg::WORD_CMD_BIT]) begin
                            cmd_stb = 1'b1;
                            state_d = rhsfp_pkg::ST_CMD;
                        end else begin
                            addr_d = byte_in[4:0];
                            cont_d = byte_in[rhsfp_pkg::WORD_CONT_BIT];
                            if (byte_in[rhsfp_pkg::WORD_READ_BIT]) begin
                                rd_stb = 1'b1;
                                shout_d = rd_data;
                                state_d = rhsfp_pkg::ST_RDATA;
                            end else begin
                                state_d = rhsfp_pkg::ST_WDATA;
                            end
                        end
                    end
                    rhsfp_pkg::ST_WDATA: begin
                        wr_stb = 1'b1;
                        if (cont_q) begin
                            // a burst stays on the fifo once it gets there
                            if (addr_q != rhsfp_pkg::ADDR_FIFO_DATA) begin
                                addr_d = addr_q + 5'h01;
                            end
                        end else begin
                            state_d = rhsfp_pkg::ST_WORD;
                        end
                    end
                    rhsfp_pkg::ST_RDATA: begin
                        if (cont_q) begin
                            rd_stb = 1'b1;
                            addr_d = addr_q + 5'h01;
                            shout_d = rd_data;
                        end else begin
                            state_d = rhsfp_pkg::ST_WORD;
                        end
                    end
                    rhsfp_pkg::ST_CMD: state_d = rhsfp_pkg::ST_CMD;
                    default: state_d = rhsfp_pkg::ST_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= rhsfp_pkg::MODE_PAR;
            strap_done_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            mosi_prev_q <= 1'b0;
            state_q <= rhsfp_pkg::ST_WORD;
            active_q <= 1'b0;
            cont_q <= 1'b0;
            bitcnt_q <= 3'h0;
            shin_q <= 8'h00;
            shout_q <= 8'h00;
            addr_q <= 5'h00;
        end else begin
            mode_q <= mode_d;
            strap_done_q <= strap_done_d;
            sclk_prev_q <= sclk_prev_d;
            mosi_prev_q <= mosi_prev_d;
            state_q <= state_d;
            active_q <= active_d;
            cont_q <= cont_d;
            bitcnt_q <= bitcnt_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            addr_q <= addr_d;
        end
    end

    assign o_mode = mode_q;
    assign o_miso = shout_q[7];
    assign o_miso_oe = link_on & (state_q == rhsfp_pkg::ST_RDATA);

    // register file, fifo and transmit state
    logic [7:0] mem_q [FIFO_DEPTH];
    logic [7:0] mem_d [FIFO_DEPTH];
    logic [3:0] wptr_q, wptr_d, rptr_q, rptr_d, cnt_q, cnt_d;
    logic [7:0] irq_status_q, irq_status_d, mask_q, mask_d;
    logic [7:0] len_hi_q, len_hi_d, len_lo_q, len_lo_d, fifo_status;
    logic [12:0] sent_q, sent_d, total;
    logic [1:0] pend_q, pend_d;
    logic ovf_q, ovf_d, tx_active_q, tx_active_d, long_q, long_d;
    logic irq_req_q, irq_req_d, irq_pin_q, irq_pin_d;
    logic push, pop, irq_clr, fifo_wr, tx_fire;

    assign total = {1'b0, len_hi_q, len_lo_q[7:4]}
        + {12'h000, |len_lo_q[3:0]};
    assign o_tx_valid = tx_active_q & (cnt_q != 4'h0);
    assign o_tx_data = mem_q[rptr_q];
    assign o_tx_last = o_tx_valid & (sent_q + 13'h0001 == total);
    assign tx_fire = o_tx_valid & i_tx_ready;
    assign fifo_wr = wr_stb & (addr_q == rhsfp_pkg::ADDR_FIFO_DATA);
    assign fifo_status = {1'b0, cnt_q >= rhsfp_pkg::FIFO_HI_LEVEL,
        tx_active_q & (cnt_q <= rhsfp_pkg::FIFO_LO_LEVEL), ovf_q,
        (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1};
    assign o_irq = irq_pin_q;

    // read multiplexer for the serial shifter
    always_comb begin
        case (rd_addr)
            rhsfp_pkg::ADDR_IRQ_STATUS: rd_data = irq_status_q;
            rhsfp_pkg::ADDR_IRQ_MASK: rd_data = mask_q;
            rhsfp_pkg::ADDR_FIFO_STATUS: rd_data = fifo_status;
            rhsfp_pkg::ADDR_TX_LEN_HI: rd_data = len_hi_q;
            rhsfp_pkg::ADDR_TX_LEN_LO: rd_data = len_lo_q;
            rhsfp_pkg::ADDR_FIFO_DATA: rd_data = mem_q[rptr_q];
            default: rd_data = 8'h00;
        endcase
    end

    // next values of registers, fifo and transmit control
    always_comb begin
        mem_d = mem_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        irq_status_d = irq_status_q;
        mask_d = mask_q;
        len_hi_d = len_hi_q;
        len_lo_d = len_lo_q;
        sent_d = sent_q;
        ovf_d = ovf_q;
        tx_active_d = tx_active_q;
        long_d = long_q;
        irq_req_d = irq_req_q;
        push = fifo_wr & (cnt_q != DEPTH4);
        pop = tx_fire;
        irq_clr = byte_done & (pend_q == 2'h2);
        pend_d = pend_q;
        if (link_reset) begin
            pend_d = 2'h0;
        end else if (rd_stb && rd_addr == rhsfp_pkg::ADDR_IRQ_STATUS) begin
            pend_d = 2'h1;
        end else if (byte_done && pend_q != 2'h0) begin
            pend_d = (pend_q == 2'h1) ? 2'h2 : 2'h0;
        end
        if (irq_clr) begin
            irq_status_d = 8'h00;
            irq_req_d = 1'b0;
        end
        if (wr_stb) begin
            case (addr_q)
                rhsfp_pkg::ADDR_IRQ_MASK: mask_d = byte_in;
                rhsfp_pkg::ADDR_TX_LEN_HI: len_hi_d = byte_in;
                rhsfp_pkg::ADDR_TX_LEN_LO: len_lo_d = byte_in;
                default: mask_d = mask_q;
            endcase
        end
        if (fifo_wr && !push) begin
            ovf_d = 1'b1;
        end
        if (push) begin
            mem_d[wptr_q] = byte_in;
            wptr_d = (wptr_q == DEPTH4 - 4'h1) ? 4'h0 : wptr_q + 4'h1;
        end
        if (pop) begin
            rptr_d = (rptr_q == DEPTH4 - 4'h1) ? 4'h0 : rptr_q + 4'h1;
            sent_d = sent_q + 13'h0001;
        end
        cnt_d = cnt_q + {3'h0, push} - {3'h0, pop};
        if (push && !tx_active_q && total != 13'h0000) begin
            tx_active_d = 1'b1;
            sent_d = 13'h0000;
            long_d = total > rhsfp_pkg::SHORT_FRAME_MAX;
            irq_status_d[rhsfp_pkg::IRQ_TX_BIT] = 1'b1;
        end
        if (pop && long_q && cnt_q == rhsfp_pkg::FIFO_LO_LEVEL + 4'h1) begin
            irq_req_d = 1'b1;
        end
        if (pop && o_tx_last) begin
            tx_active_d = 1'b0;
            irq_status_d[rhsfp_pkg::IRQ_TX_BIT] = 1'b1;
            irq_req_d = 1'b1;
        end
        if (cmd_stb && byte_in[4:0] == rhsfp_pkg::CMD_FIFO_RESET) begin
            wptr_d = 4'h0;
            rptr_d = 4'h0;
            cnt_d = 4'h0;
            ovf_d = 1'b0;
            tx_active_d = 1'b0;
        end
        irq_pin_d = irq_req_d | (tx_active_d & long_d
            & (cnt_d < rhsfp_pkg::FIFO_LO_LEVEL
               | cnt_d > rhsfp_pkg::FIFO_HI_LEVEL));
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q <= '{default: rhsfp_pkg::REG_RESET};
            wptr_q <= 4'h0;
            rptr_q <= 4'h0;
            cnt_q <= 4'h0;
            irq_status_q <= rhsfp_pkg::REG_RESET;
            mask_q <= rhsfp_pkg::REG_RESET;
            len_hi_q <= rhsfp_pkg::REG_RESET;
            len_lo_q <= rhsfp_pkg::REG_RESET;
            sent_q <= 13'h0000;
            pend_q <= 2'h0;
            ovf_q <= 1'b0;
            tx_active_q <= 1'b0;
            long_q <= 1'b0;
            irq_req_q <= 1'b0;
            irq_pin_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            irq_status_q <= irq_status_d;
            mask_q <= mask_d;
            len_hi_q <= len_hi_d;
            len_lo_q <= len_lo_d;
            sent_q <= sent_d;
            pend_q <= pend_d;
            ovf_q <= ovf_d;
            tx_active_q <= tx_active_d;
            long_q <= long_d;
            irq_req_q <= irq_req_d;
            irq_pin_q <= irq_pin_d;
        end
    end

    // checks on the logic above
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    chk_fifo_bound: assert property (cnt_q <= DEPTH4)
        else $error("fifo count above depth");
    chk_ovf_drop: assert property (
        fifo_wr && cnt_q == DEPTH4 && !tx_fire |=> ovf_q && cnt_q == DEPTH4)
        else $error("write to full fifo not dropped");
    chk_tx_autostart: assert property (
        push && !tx_active_q && total != 13'h0000 |=> tx_active_q)
        else $error("transmission did not start");
    chk_tx_flag: assert property (
        $rose(tx_active_q) |-> irq_status_q[rhsfp_pkg::IRQ_TX_BIT])
        else $error("transmit flag missing at start");
    chk_cnt_field: assert property (
        cnt_q != 4'h0 |-> fifo_status[3:0] == cnt_q - 4'h1)
        else $error("counter field wrong");
    chk_hi_flag: assert property (
        fifo_status[rhsfp_pkg::FIFO_HI_BIT] == (cnt_q >= 4'h9))
        else $error("level-high flag wrong");
    chk_eof_len: assert property (
        tx_fire && sent_q + 13'h0001 == total |=> !tx_active_q
        ##0 irq_req_q)
        else $error("frame did not end at length");
    chk_ss_reset: assert property (
        ss_mode && pins_s.ssn |=> bitcnt_q == 3'h0
        && state_q == rhsfp_pkg::ST_WORD)
        else $error("select high did not reset link");
    chk_noss_start: assert property (
        noss_mode && start_cond |=> active_q && bitcnt_q == 3'h0)
        else $error("start condition not armed");
    chk_status_clear: assert property (
        $fell(irq_status_q[rhsfp_pkg::IRQ_TX_BIT]) |->
        $past(pend_q) == 2'h2 && $past(byte_done))
        else $error("status cleared too early");
    chk_short_irq: assert property (
        tx_active_q && !long_q && !irq_req_q && !tx_fire |=> !o_irq)
        else $error("short frame interrupted early");
    chk_read_load: assert property (
        rd_stb && state_q == rhsfp_pkg::ST_WORD |=> shout_q == $past(rd_data)
        ##1 o_miso_oe)
        else $error("read byte not presented");

    cov_tx_frame: cover property (tx_fire && o_tx_last);
    cov_overflow: cover property ($rose(ovf_q));
    cov_status_clear: cover property (irq_clr);
    cov_cont_read: cover property (byte_done && cont_q
        && state_q == rhsfp_pkg::ST_RDATA);
endmodule // rhsfp_top

// [tb/rhsfp_host.sv]
// host serial master model for the reader serial port
`timescale 1ns/100ps
module rhsfp_host (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_mosi,
    output logic o_ssn
);
    logic noss;

    // idle link: clock low and still, select high
    initial begin
        noss = 1'b0;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_ssn = 1'b1;
    end

    // one link clock phase, 80 ns, faster than the suggested rate
    task automatic ph();
        repeat (20) @(posedge i_clk);
    endtask

    // open a frame: select low, or data rise while clock high
    task automatic start();
        if (noss) begin
            o_sclk <= 1'b1;
            ph();
            o_mosi <= 1'b1;
            ph();
            o_sclk <= 1'b0;
        end else begin
            o_ssn <= 1'b0;
        end
        ph();
    endtask

    // close a frame: select high, or data fall while clock high
    task automatic stop();
        if (noss) begin
            o_mosi <= 1'b1;
            ph();
            o_sclk <= 1'b1;
            ph();
            o_mosi <= 1'b0;
            ph();
            o_sclk <= 1'b0;
        end else begin
            o_ssn <= 1'b1;
        end
        ph();
    endtask

    // one word msb first; data moves with clock low
    // the bit left at the last rise is read just before the next rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(posedge i_clk);
            o_mosi <= tx[i];
            ph();
            rx[i] = i_miso;
            o_sclk <= 1'b1;
            ph();
            o_sclk <= 1'b0;
        end
    endtask
endmodule // rhsfp_host

// [tb/tb.sv]
// self-checking bench for the reader host serial fifo port
`timescale 1ns/100ps
module tb;
    logic i_clk;
    logic i_resetn;
    logic [2:0] i_strap;
    logic sclk;
    logic mosi;
    logic ssn;
    logic miso;
    logic miso_oe;
    logic miso_w;
    logic irq;
    logic tx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    rhsfp_pkg::rhsfp_mode_t mode;
    int n_errors;
    int num_checks;
    int cyc = 0;
    logic [7:0] r;
    logic [7:0] r2;

    // 250 MHz clock
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    // released miso shows the inverse of its last bit
    assign miso_w = miso_oe ? miso : ~miso;

    rhsfp_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_strap(i_strap),
        .i_sclk(sclk), .i_mosi(mosi), .i_ssn(ssn), .o_miso(miso),
        .o_miso_oe(miso_oe), .o_irq(irq), .i_tx_ready(tx_ready),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
        .o_mode(mode));
    rhsfp_host host (.i_clk(i_clk), .i_miso(miso_w), .o_sclk(sclk),
        .o_mosi(mosi), .o_ssn(ssn));

    // compare one value and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask

    // print counts and verdict, then stop
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // reset with a strap code, then wait until the link may be used
    task automatic rst(input logic [2:0] s);
        i_resetn <= 1'b0;
        i_strap <= s;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask

    // a frame of one or two words
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit two);
        host.start();
        host.xfer(a, r);
        if (two) begin
            host.xfer(d, r);
        end
        host.stop();
    endtask

    // single read, host holds data low while reading
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host.start();
        host.xfer(a, r);
        host.xfer(8'h00, d);
        host.stop();
    endtask

    // five of the eight strap codes each pick their port mode
    task automatic t_mode();
        logic [2:0] code [5] = '{3'h0, 3'h7, 3'h6, 3'h4, 3'h2};
        logic [2:0] exp [5] = '{3'h1, 3'h1, 3'h2, 3'h4, 3'h2};
        for (int i = 0; i < 5; i++) begin
            rst(code[i]);
            chk({5'h00, mode}, {5'h00, exp[i]}, "mode");
        end
        $display("test mode done");
    endtask

    // write and read back, and a write to a read-only place
    task automatic t_reg();
        wr(8'h1d, 8'ha5, 1'b1);
        rd(8'h5d, r2);
        chk(r2, 8'ha5, "len_hi");
        wr(8'h1c, 8'hff, 1'b1);
        rd(8'h5c, r2);
        chk(r2, 8'h00, "fifo_status");
        $display("test reg done");
    endtask

    // n-byte frame loaded by burst, drained back to back
    task automatic t_tx(input int n);
        wr(8'h8f, 8'h00, 1'b0);
        host.start();
        host.xfer(8'h3d, r);
        host.xfer(8'h00, r);
        host.xfer({n[3:0], 4'h0}, r);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h30 + 8'(i), r);
        end
        host.stop();
        chk({7'h00, tx_valid}, 8'h01, "tx start");
        rd(8'h5c, r2);
        chk(r2, 8'(n - 1), "fifo count");
        host.start();
        host.xfer(8'h7d, r);
        host.xfer(8'h00, r2);
        chk(r2, 8'h00, "burst hi");
        host.xfer(8'h00, r2);
        chk(r2, {n[3:0], 4'h0}, "burst lo");
        host.stop();
        tx_ready <= 1'b1;
        for (int k = 0; k < n; k++) begin
            @(negedge i_clk);
            chk(tx_data, 8'h30 + 8'(k), "tx byte");
            chk({7'h00, tx_last}, {7'h00, k == n - 1}, "last");
            chk({7'h00, irq}, {7'h00, k >= n - 3 && n > 4}, "irq");
            @(posedge i_clk);
        end
        tx_ready <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk({7'h00, irq}, 8'h01, "end irq");
        rd(8'h6c, r2);
        chk(r2, 8'h80, "tx flag");
        chk({7'h00, irq}, 8'h01, "kept irq");
        host.start();
        host.xfer(8'h6c, r);
        host.xfer(8'h00, r2);
        host.xfer(8'h00, r);
        host.stop();
        chk(r2, 8'h80, "tx flag");
        chk({7'h00, irq}, 8'h00, "cleared irq");
        $display("test tx %0d done", n);
    endtask

    // thirteen bytes into twelve places, then the clear command
    task automatic t_ovf();
        wr(8'h8f, 8'h00, 1'b0);
        host.start();
        host.xfer(8'h3d, r);
        host.xfer(8'h00, r);
        host.xfer(8'hf0, r);
        for (int i = 0; i < 13; i++) begin
            host.xfer(8'(i + 1), r);
        end
        host.stop();
        rd(8'h5c, r2);
        chk(r2, 8'h5b, "overflow");
        chk({7'h00, irq}, 8'h01, "level irq");
        chk(tx_data, 8'h01, "oldest byte");
        wr(8'h8f, 8'h00, 1'b0);
        rd(8'h5c, r2);
        chk(r2, 8'h00, "emptied");
        $display("test ovf done");
    endtask

    // hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // main sequence
    initial begin
        i_resetn = 1'b0;
        i_strap = 3'h0;
        tx_ready = 1'b0;
        n_errors = 0;
        num_checks = 0;
        t_mode();
        rst(3'h6);
        t_reg();
        t_tx(4);
        t_tx(6);
        t_ovf();
        host.noss = 1'b1;
        rst(3'h4);
        t_reg();
        t_tx(6);
        results();
    end
endmodule // tb
